// ===== src/cfg_loader_params.svh
`ifndef CFG_LOADER_PARAMS_SVH
`define CFG_LOADER_PARAMS_SVH

// ----------------------------------------
// Configuration memory word addresses
// ----------------------------------------
`define EE_ADDR_W 8
`define EE_WORD_SIZE 8'h12
`define EE_WORD_PIN_B 8'h10
`define EE_WORD_PIN_A 8'h20

// ----------------------------------------
// Size word fields
// ----------------------------------------
`define SIZE_CODE_HI 12
`define SIZE_CODE_LO 10
`define SIZE_CODE_MIN 3'h0
`define SIZE_CODE_RSVD 3'h7
`define SIZE_BYTES_MIN 16'h0080
`define SIZE_BYTES_BASE 16'h0200
`define COMMON_POWER_HI 7
`define COMMON_POWER_LO 0

// ----------------------------------------
// Pin control word fields
// ----------------------------------------
`define PW_UPPER_A_DIR 15
`define PW_UPPER_B_DIR 14
`define PW_PIN1_DIR 9
`define PW_PIN0_DIR 8
`define PW_UPPER_A_VAL 7
`define PW_UPPER_B_VAL 6
`define PW_PHY_PM_EN 3
`define PW_PIN1_VAL 1
`define PW_PIN0_VAL 0

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ADDR_W 8
`define OFF_DEV_CTRL 8'h00
`define OFF_EXT_CTRL_A 8'h04
`define OFF_EXT_CTRL_B 8'h08
`define OFF_PM_CTRL_STATUS 8'h0C
`define OFF_PM_DATA 8'h10
`define OFF_SIZE_STATUS 8'h14
`define OFF_LOADER_CFG 8'h18

// ----------------------------------------
// Register fields and reset values
// ----------------------------------------
`define DEV_PHY_PM_EN_BIT 0
`define PM_SEL_HI 12
`define PM_SEL_LO 9
`define PM_SEL_COMMON 4'h8
`define LCFG_PM_DISABLE_BIT 0
`define SIZE_ST_DONE_BIT 31
`define SIZE_ST_RSVD_BIT 30
`define SIZE_ST_BIT9 19
`define SIZE_ST_CODE_HI 18
`define SIZE_ST_CODE_LO 16
`define RST_DEV_CTRL 1'b1
`define RST_PIN_CTRL 8'h00
`define RST_PM_SEL 4'h0
`define RST_WORD 16'h0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define DATA_ZERO 32'h0000_0000

`endif

// ===== src/cfg_loader_pkg.sv
package cfg_loader_pkg;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic upper_a_value;
    logic upper_b_value;
    logic pin1_value;
    logic pin0_value;
    logic upper_a_direction;
    logic upper_b_direction;
    logic pin1_direction;
    logic pin0_direction;
  } pin_ctrl_t;

  typedef struct packed {
    logic reserved_code;
    logic bit9;
    logic [2:0] code;
    logic [15:0] bytes;
  } size_info_t;

  typedef enum logic [2:0] {
    LD_START = 3'b000,
    LD_SIZE = 3'b001,
    LD_PIN_B = 3'b010,
    LD_PIN_A = 3'b011,
    LD_DONE = 3'b100
  } load_state_t;

endpackage : cfg_loader_pkg

// ===== src/eeprom_config_word_loader.sv
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
// Contract
// - Decode size bits 12:10; 000 is 1 Kb, doubling 4-128 Kb, 111 reserved.
// - Power data returns common power when selector is 8, signature valid, PM on.
// - Common power is shared-logic power and heat in tenths of a watt.
// - Copy word bits 15,14 into upper pin direction bits after power-up.
// - Copy word bits 9,8 into pin 1 and 0 direction bits.
// - Copy word bits 7,6 into upper pin output value bits.
// - Copy word bit 3 into the PHY power-management enable bit.
// - Copy word bits 1,0 into pin 1 and 0 output value bits.
// - Word 10h configures function B, word 20h function A.
`include "cfg_loader_params.svh"

module eeprom_config_word_loader
  import cfg_loader_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // Configuration memory word read port
  output logic ee_req,
  output logic [`EE_ADDR_W-1:0] ee_addr,
  input wire logic [15:0] ee_rdata,
  input wire logic ee_rvalid,
  input wire logic signature_valid,
  // Loaded state
  output pin_ctrl_t ext_ctrl_a,
  output pin_ctrl_t ext_ctrl_b,
  output logic phy_power_mgmt_enable,
  output logic load_done,
  // AXI4-Lite slave
  input wire logic [`ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [`ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic size_info_t size_decode(input logic [15:0] w);
    size_info_t s;
    s = '0;
    s.code = w[`SIZE_CODE_HI:`SIZE_CODE_LO];
    s.reserved_code = (s.code == `SIZE_CODE_RSVD);
    s.bit9 = (s.code != `SIZE_CODE_MIN);
    s.bytes = (s.code == `SIZE_CODE_MIN) ? `SIZE_BYTES_MIN :
              s.reserved_code ? '0 :
              `SIZE_BYTES_BASE << (s.code - 3'h1);
    return s;
  endfunction : size_decode

  function automatic pin_ctrl_t pin_decode(input logic [15:0] w);
    pin_ctrl_t p;
    p.upper_a_direction = w[`PW_UPPER_A_DIR];
    p.upper_b_direction = w[`PW_UPPER_B_DIR];
    p.pin1_direction = w[`PW_PIN1_DIR];
    p.pin0_direction = w[`PW_PIN0_DIR];
    p.upper_a_value = w[`PW_UPPER_A_VAL];
    p.upper_b_value = w[`PW_UPPER_B_VAL];
    p.pin1_value = w[`PW_PIN1_VAL];
    p.pin0_value = w[`PW_PIN0_VAL];
    return p;
  endfunction : pin_decode

  function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : strb_merge

  function automatic logic addr_mapped(input logic [`ADDR_W-1:0] a);
    return (a == `OFF_DEV_CTRL) || (a == `OFF_EXT_CTRL_A) || (a == `OFF_EXT_CTRL_B) ||
           (a == `OFF_PM_CTRL_STATUS) || (a == `OFF_PM_DATA) ||
           (a == `OFF_SIZE_STATUS) || (a == `OFF_LOADER_CFG);
  endfunction : addr_mapped

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  load_state_t state_reg;
  logic [15:0] size_word_reg;
  logic [3:0] pm_sel_reg;
  logic pm_disable_reg;
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [`ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_go;
  logic [31:0] wr_val;
  size_info_t size_info;
  logic [7:0] common_power;
  logic [31:0] rd_val;

  assign size_info = size_decode(size_word_reg);
  assign common_power = size_word_reg[`COMMON_POWER_HI:`COMMON_POWER_LO];
  assign wr_go = aw_hold_reg && w_hold_reg && !s_bvalid;
  assign wr_val = strb_merge(`DATA_ZERO, wdata_reg, wstrb_reg);

  // ----------------------------------------
  // Load sequencer
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= LD_START;
      ee_req <= 1'b0;
      ee_addr <= `EE_WORD_SIZE;
      load_done <= 1'b0;
    end else begin
      unique case (state_reg)
        LD_START: begin
          state_reg <= LD_SIZE;
          ee_req <= 1'b1;
          ee_addr <= `EE_WORD_SIZE;
        end
        LD_SIZE: begin
          if (ee_rvalid) begin
            state_reg <= LD_PIN_B;
            ee_addr <= `EE_WORD_PIN_B;
          end
        end
        LD_PIN_B: begin
          if (ee_rvalid) begin
            state_reg <= LD_PIN_A;
            ee_addr <= `EE_WORD_PIN_A;
          end
        end
        LD_PIN_A: begin
          if (ee_rvalid) begin
            state_reg <= LD_DONE;
            ee_req <= 1'b0;
            load_done <= 1'b1;
          end
        end
        LD_DONE: state_reg <= LD_DONE;
        default: state_reg <= LD_START;
      endcase
    end
  end

  // ----------------------------------------
  // Size and common power word
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      size_word_reg <= `RST_WORD;
    end else if (state_reg == LD_SIZE && ee_rvalid) begin
      size_word_reg <= ee_rdata;
    end
  end

  // ----------------------------------------
  // Extended control, function B
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_ctrl_b <= `RST_PIN_CTRL;
    end else if (state_reg == LD_PIN_B && ee_rvalid) begin
      ext_ctrl_b <= pin_decode(ee_rdata);
    end else if (wr_go && awaddr_reg == `OFF_EXT_CTRL_B) begin
      ext_ctrl_b <= wr_val[7:0];
    end
  end

  // ----------------------------------------
  // Extended control, function A
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_ctrl_a <= `RST_PIN_CTRL;
    end else if (state_reg == LD_PIN_A && ee_rvalid) begin
      ext_ctrl_a <= pin_decode(ee_rdata);
    end else if (wr_go && awaddr_reg == `OFF_EXT_CTRL_A) begin
      ext_ctrl_a <= wr_val[7:0];
    end
  end

  // ----------------------------------------
  // Device control
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phy_power_mgmt_enable <= `RST_DEV_CTRL;
    end else if (state_reg == LD_PIN_A && ee_rvalid) begin
      phy_power_mgmt_enable <= ee_rdata[`PW_PHY_PM_EN];
    end else if (wr_go && awaddr_reg == `OFF_DEV_CTRL) begin
      phy_power_mgmt_enable <= wr_val[`DEV_PHY_PM_EN_BIT];
    end
  end

  // ----------------------------------------
  // Power management selector and loader config
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pm_sel_reg <= `RST_PM_SEL;
      pm_disable_reg <= 1'b0;
    end else if (wr_go) begin
      if (awaddr_reg == `OFF_PM_CTRL_STATUS) begin
        pm_sel_reg <= wr_val[`PM_SEL_HI:`PM_SEL_LO];
      end
      if (awaddr_reg == `OFF_LOADER_CFG) begin
        pm_disable_reg <= wr_val[`LCFG_PM_DISABLE_BIT];
      end
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb begin
    rd_val = `DATA_ZERO;
    unique case (s_araddr)
      `OFF_DEV_CTRL: rd_val[`DEV_PHY_PM_EN_BIT] = phy_power_mgmt_enable;
      `OFF_EXT_CTRL_A: rd_val[7:0] = ext_ctrl_a;
      `OFF_EXT_CTRL_B: rd_val[7:0] = ext_ctrl_b;
      `OFF_PM_CTRL_STATUS: rd_val[`PM_SEL_HI:`PM_SEL_LO] = pm_sel_reg;
      `OFF_PM_DATA: if (signature_valid && !pm_disable_reg && pm_sel_reg == `PM_SEL_COMMON) begin
        rd_val[7:0] = common_power;
      end
      `OFF_SIZE_STATUS: begin
        rd_val[15:0] = size_info.bytes;
        rd_val[`SIZE_ST_BIT9] = size_info.bit9;
        rd_val[`SIZE_ST_CODE_HI:`SIZE_ST_CODE_LO] = size_info.code;
        rd_val[`SIZE_ST_RSVD_BIT] = size_info.reserved_code;
        rd_val[`SIZE_ST_DONE_BIT] = load_done;
      end
      `OFF_LOADER_CFG: rd_val[`LCFG_PM_DISABLE_BIT] = pm_disable_reg;
      default: rd_val = `DATA_ZERO;
    endcase
  end

  // ----------------------------------------
  // Write address and data capture
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_awready <= 1'b0;
      aw_hold_reg <= 1'b0;
      awaddr_reg <= '0;
    end else begin
      s_awready <= 1'b0;
      if (wr_go) begin
        aw_hold_reg <= 1'b0;
      end else if (s_awvalid && s_awready) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= s_awaddr;
      end else if (load_done && s_awvalid && !aw_hold_reg) begin
        s_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_wready <= 1'b0;
      w_hold_reg <= 1'b0;
      wdata_reg <= `DATA_ZERO;
      wstrb_reg <= '0;
    end else begin
      s_wready <= 1'b0;
      if (wr_go) begin
        w_hold_reg <= 1'b0;
      end else if (s_wvalid && s_wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_wdata;
        wstrb_reg <= s_wstrb;
      end else if (load_done && s_wvalid && !w_hold_reg) begin
        s_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Write response
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_bvalid <= 1'b0;
      s_bresp <= `RESP_OKAY;
    end else if (wr_go) begin
      s_bvalid <= 1'b1;
      s_bresp <= addr_mapped(awaddr_reg) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= `DATA_ZERO;
      s_rresp <= `RESP_OKAY;
    end else begin
      s_arready <= 1'b0;
      if (s_arvalid && s_arready) begin
        s_rvalid <= 1'b1;
        s_rdata <= rd_val;
        s_rresp <= addr_mapped(s_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end else if (load_done && s_arvalid && !s_rvalid) begin
        s_arready <= 1'b1;
      end
    end
  end

endmodule : eeprom_config_word_loader

// ===== tb/eeprom_config_word_loader_props.sv
`timescale 1ns/10ps
`include "cfg_loader_params.svh"
module eeprom_config_word_loader_props
  import cfg_loader_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ee_req,
  input wire logic [`EE_ADDR_W-1:0] ee_addr,
  input wire logic [15:0] ee_rdata,
  input wire logic ee_rvalid,
  input wire logic signature_valid,
  input wire pin_ctrl_t ext_ctrl_a,
  input wire pin_ctrl_t ext_ctrl_b,
  input wire logic phy_power_mgmt_enable,
  input wire logic load_done,
  input wire logic s_awready,
  input wire logic s_wready,
  input wire logic [`ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic s_rvalid
);
  function automatic pin_ctrl_t map_w(input logic [15:0] d);
    return {d[7], d[6], d[1], d[0], d[15], d[14], d[9], d[8]};
  endfunction : map_w

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence took(logic [7:0] a);
    ee_req && ee_rvalid && ee_addr == a;
  endsequence

  chk_size_then_b: assert property (
    took(`EE_WORD_SIZE) |=> ee_req && ee_addr == `EE_WORD_PIN_B) else $error("bad word order");
  chk_pin_b_load: assert property (
    took(`EE_WORD_PIN_B) |=> ext_ctrl_b == map_w($past(ee_rdata))) else $error("pin B wrong");
  chk_pin_a_load: assert property (
    took(`EE_WORD_PIN_A) |=> ext_ctrl_a == map_w($past(ee_rdata))
      && phy_power_mgmt_enable == $past(ee_rdata[3]) && load_done && !ee_req)
    else $error("pin A wrong");
  chk_req_holds: assert property (
    ee_req && !ee_rvalid |=> ee_req && $stable(ee_addr)) else $error("request dropped");
  chk_early_hold: assert property (
    !load_done |-> !s_awready && !s_wready && !s_arready) else $error("early access");
  chk_done_stays: assert property (
    load_done |=> load_done [*2]) else $error("done fell");
  chk_done_quiet: assert property (
    load_done |-> !ee_req) else $error("request after done");
  chk_power_zero: assert property (
    s_arvalid && s_arready && s_araddr == `OFF_PM_DATA && !signature_valid
      |=> s_rvalid && s_rdata == `DATA_ZERO) else $error("power data leaked");
endmodule : eeprom_config_word_loader_props

bind eeprom_config_word_loader eeprom_config_word_loader_props i_props (
  .aclk(aclk), .aresetn(aresetn), .ee_req(ee_req), .ee_addr(ee_addr),
  .ee_rdata(ee_rdata), .ee_rvalid(ee_rvalid), .signature_valid(signature_valid),
  .ext_ctrl_a(ext_ctrl_a), .ext_ctrl_b(ext_ctrl_b),
  .phy_power_mgmt_enable(phy_power_mgmt_enable), .load_done(load_done),
  .s_awready(s_awready), .s_wready(s_wready), .s_araddr(s_araddr),
  .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rvalid(s_rvalid)
);

// ===== tb/cfg_eeprom_model.sv
`timescale 1ns/10ps
`include "cfg_loader_params.svh"
module cfg_eeprom_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] lat,
  input wire logic ee_req,
  input wire logic [`EE_ADDR_W-1:0] ee_addr,
  output logic [15:0] ee_rdata,
  output logic ee_rvalid
);
  logic [15:0] img [0:255];
  logic [3:0] cnt;

  // ----------------------------------------
  // Image defaults
  // ----------------------------------------
  initial begin
    ee_rdata = 16'h5A5A;
    foreach (img[i]) img[i] = 16'h0000;
    img[`EE_WORD_PIN_B] = 16'hDFDE;
    img[`EE_WORD_PIN_A] = 16'hDFDE;
  end

  // Answer after lat idle cycles; data line toggles when idle
  always @(posedge aclk) begin
    ee_rvalid <= 1'b0;
    ee_rdata <= ~ee_rdata;
    if (!aresetn) begin
      cnt <= 4'h0;
    end else if (ee_req && !ee_rvalid) begin
      if (cnt == lat) begin
        ee_rvalid <= 1'b1;
        ee_rdata <= img[ee_addr];
        cnt <= 4'h0;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule : cfg_eeprom_model

// ===== tb/tb_eeprom_config_word_loader.sv
`timescale 1ns/10ps
`include "cfg_loader_params.svh"
module tb_eeprom_config_word_loader
  import cfg_loader_pkg::*;
;
  logic aclk = 0, aresetn = 0, ee_req, ee_rvalid, signature_valid = 1, phy, load_done;
  logic [7:0] ee_addr, awaddr = 0, araddr = 0;
  logic [15:0] ee_rdata, a_w;
  logic [3:0] lat = 0, wstrb = 4'hF;
  pin_ctrl_t ext_a, ext_b;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 0, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [2:0] code;
  int mismatches = 0, n_tests = 0;

  always #5 aclk = ~aclk;

  eeprom_config_word_loader i_dut (.aclk(aclk), .aresetn(aresetn), .ee_req(ee_req),
    .ee_addr(ee_addr), .ee_rdata(ee_rdata), .ee_rvalid(ee_rvalid),
    .signature_valid(signature_valid), .ext_ctrl_a(ext_a), .ext_ctrl_b(ext_b),
    .phy_power_mgmt_enable(phy), .load_done(load_done), .s_awaddr(awaddr),
    .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb),
    .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid),
    .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
    .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready));
  cfg_eeprom_model i_mem (.aclk(aclk), .aresetn(aresetn), .lat(lat), .ee_req(ee_req),
    .ee_addr(ee_addr), .ee_rdata(ee_rdata), .ee_rvalid(ee_rvalid));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw, w;
    aw = 1;
    w = 1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && awready === 1'b1) begin aw = 0; awvalid <= 0; end
      if (w && wready === 1'b1) begin w = 0; wvalid <= 0; end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    rs = bresp;
    bready <= 0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    while (rvalid !== 1'b1) @(posedge aclk);
    v = rdata;
    rs = rresp;
    rready <= 0;
  endtask : axi_rd

  function automatic logic [31:0] pins(input logic [15:0] w);
    return {24'h0, w[7], w[6], w[1], w[0], w[15], w[14], w[9], w[8]};
  endfunction : pins

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    @(posedge aclk);
    for (int c = 0; c < 8; c++) begin
      code = c[2:0];
      a_w = 16'hDFDE ^ 16'(16'h2149 * c);
      i_mem.img[`EE_WORD_SIZE] = {3'h0, code, code != 3'h0, 1'b0, 8'h2A};
      i_mem.img[`EE_WORD_PIN_A] = a_w;
      i_mem.img[`EE_WORD_PIN_B] = ~a_w;
      aresetn <= 0;
      lat <= c[0] ? 4'h3 : 4'h0;
      repeat (4) @(posedge aclk);
      aresetn <= 1;
      axi_rd(`OFF_EXT_CTRL_A, d, r);
      chk("done_before_read", {31'h0, load_done}, 32'h1);
      chk("pins_a", d, pins(a_w));
      chk("pins_a_port", {24'h0, ext_a}, pins(a_w));
      axi_rd(`OFF_EXT_CTRL_B, d, r);
      chk("pins_b", d, pins(~a_w));
      chk("pins_b_port", {24'h0, ext_b}, pins(~a_w));
      axi_rd(`OFF_DEV_CTRL, d, r);
      chk("phy_pm", d, {31'h0, a_w[3]});
      chk("phy_pm_port", {31'h0, phy}, {31'h0, a_w[3]});
      axi_rd(`OFF_SIZE_STATUS, d, r);
      chk("size", {d[31:30], d[19:16], d[15:0]}, {1'b1, code == 3'h7, code != 3'h0, code,
        code == 3'h0 ? 16'h0080 : code == 3'h7 ? 16'h0000 : 16'h0100 << code});
      $display("test load code %0d done", c);
    end
    for (int i = 0; i < 4; i++) begin
      signature_valid <= i != 1;
      axi_wr(`OFF_LOADER_CFG, {31'h0, i == 2}, r);
      axi_wr(`OFF_PM_CTRL_STATUS, i == 3 ? 32'h0000_0800 : 32'h0000_1000, r);
      axi_rd(`OFF_PM_DATA, d, r);
      chk("power_data", d, i == 0 ? 32'h0000_002A : `DATA_ZERO);
    end
    $display("test power data done");
    axi_wr(`OFF_EXT_CTRL_A, 32'h0000_00A5, r);
    chk("rw_bresp", {30'h0, r}, {30'h0, `RESP_OKAY});
    axi_rd(`OFF_EXT_CTRL_A, d, r);
    chk("rw_ext_a", d, 32'h0000_00A5);
    chk("rw_rresp", {30'h0, r}, {30'h0, `RESP_OKAY});
    chk("ext_a_port", {24'h0, ext_a}, 32'h0000_00A5);
    wstrb <= 4'hE;
    axi_wr(`OFF_EXT_CTRL_A, 32'h0000_005A, r);
    wstrb <= 4'hF;
    axi_rd(`OFF_EXT_CTRL_A, d, r);
    chk("strobe_lane0", d, `DATA_ZERO);
    axi_wr(8'h1C, 32'hFFFF_FFFF, r);
    chk("unmapped_bresp", {30'h0, r}, {30'h0, `RESP_SLVERR});
    axi_rd(8'h1C, d, r);
    chk("unmapped_rresp", {30'h0, r}, {30'h0, `RESP_SLVERR});
    chk("unmapped_rdata", d, `DATA_ZERO);
    $display("test register access done");
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    stop_test();
  end
endmodule : tb_eeprom_config_word_loader
